// ===== design/emipc_top.sv
/*
 * Event latching, reset entry and data bus parking of the external memory
 * interface. Registers are reached through a simple word-wide register port.
 * Assumes the access sequencers supply the read, write and strobe-extension
 * strobes on the same clock, and that read data on the bus are valid at
 * the edge that carries the last-read strobe.
 */
// Function
// - When idle, keep driving the data bus with the last written value.
// - Release the bus during reads; park again right after the last read word.
// - Async read finishing in self-refresh leaves the bus tri-stated.
// - Pin reset, watchdog timeout or debugger reset return everything to reset.
// - Pin or watchdog reset ends at clock-controller release; debugger reset ends directly.
// - On leaving reset, SDRAM initialization starts without software.
// - Two events only, wait rising edge and async timeout, one interrupt.
// - Wait rise detection ignores the programmed wait polarity.
// - Timeout fires when wait stays active beyond the maximum extension count.
// - Writing 1 in enable-set enables the event; 0 does nothing.
// - Writing 1 in enable-clear disables the event; 0 does nothing.
// - Both enable registers read back the current enable state.
// - Raw status bit sets on its event whether enabled or not.
// - Masked status bit sets only for an event that is enabled.
// - Writing 1 to raw status clears raw and matching masked bit.
// - Interrupt is ORed with another controller's request onto the CPU input.
// - In host non-multiplexed mode upper data lines are host inputs, not driven.
// - On counter expiry the access proceeds to hold, which is the timeout.
`timescale 1ns/1ps
`default_nettype none

module emipc_top (
	// Clock and reset sources
	input  wire logic                         CLK_I,
	input  wire logic                         RST_I,
	input  wire logic                         WDOG_RST_I,
	input  wire logic                         DBG_RST_I,
	input  wire logic                         CLKCTL_RELEASE_I,
	// Register port
	input  wire emipc_pkg::emipc_reg_req_type REG_REQ_I,
	output logic [emipc_pkg::DATA_W-1:0]      REG_RDATA_O,
	output logic                              REG_RVALID_O,
	// Sequencer strobes
	input  wire logic                         WR_STROBE_I,
	input  wire logic [emipc_pkg::DATA_W-1:0] WR_DATA_I,
	input  wire logic                         RD_CMD_I,
	input  wire logic                         RD_LAST_I,
	input  wire logic                         RD_ASYNC_I,
	input  wire logic                         SELF_REFRESH_I,
	input  wire logic                         STROBE_EXT_I,
	// Memory pins
	input  wire logic                         EXT_WAIT_PIN_I,
	input  wire logic [emipc_pkg::DATA_W-1:0] MEMORY_DATA_BUS_I,
	output logic [emipc_pkg::DATA_W-1:0]      MEMORY_DATA_BUS_O,
	output logic [emipc_pkg::DATA_W-1:0]      MEMORY_DATA_BUS_OE_O,
	// Host port sharing
	input  wire logic                         HOST_NONMUX_SELECT_I,
	output logic [emipc_pkg::ASYNC_BUS_WIDTH_W-1:0]     ASYNC_BUS_WIDTH_O,
	// Status toward sequencers and CPU
	input  wire logic                         DMA_NMI_I,
	output logic [emipc_pkg::DATA_W-1:0]      RD_DATA_O,
	output logic                              WAIT_ACTIVE_O,
	output logic                              HOLD_GO_O,
	output logic                              SDRAM_INIT_START_O,
	output logic                              IRQ_O,
	output logic                              CPU_NONMASKABLE_INPUT_O
);

	import emipc_pkg::*;

	typedef struct packed {
		logic                 hold;
		logic                 in_reset;
		logic                 init_start;
		logic [MAX_EXTEND_WAIT_COUNT_W-1:0]    max_extend_wait_count;
		logic                 wpol;
		logic [ASYNC_BUS_WIDTH_W-1:0]   async_bus_width;
		logic [ASYNC_BUS_WIDTH_W-1:0]   width;
		logic [EVT_W-1:0]     raw;
		logic [EVT_W-1:0]     masked;
		logic [EVT_W-1:0]     en;
		logic                 wait_q;
		logic [MAX_EXTEND_WAIT_COUNT_W-1:0]    ext_cnt;
		logic                 expired;
		logic                 hold_go;
		logic                 wait_act;
		emipc_park_type       park;
		logic [DATA_W-1:0]    park_data;
		logic [DATA_W-1:0]    oe;
		logic [DATA_W-1:0]    rd_data;
		logic [DATA_W-1:0]    rdata;
		logic                 rvalid;
		logic                 irq;
		logic                 nmi;
	} emipc_state_type;

	// Pin reset and reset entry both land here; hold waits for the release
	localparam emipc_state_type ST_RST = '{
		hold: 1'b1, in_reset: 1'b1, max_extend_wait_count: RST_MAX_EXTEND_WAIT_COUNT, wpol: RST_WPOL,
		async_bus_width: RST_ASYNC_BUS_WIDTH, width: RST_ASYNC_BUS_WIDTH, park: PARK_DRIVE, default: '0};

	emipc_state_type st_ff;
	emipc_state_type nxt_st;

	logic             wait_sync;
	logic             rst_src;
	logic             rst_int;
	logic             reg_wr;
	logic [EVT_W-1:0] evt;
	logic [EVT_W-1:0] clr;
	logic             wait_active;
	logic             drive;

	// ----------------------------------------------------------------
	// Reset sources
	// ----------------------------------------------------------------
	// Any source, or a pending release, keeps all block state at reset
	assign rst_src = RST_I | WDOG_RST_I | DBG_RST_I;
	assign rst_int = rst_src | st_ff.hold;

	// Wait pin synchroniser; edge detection only sees its filtered level
	emipc_sync3 u_wait_sync (
		.clk_i   (CLK_I),
		.rst_i   (rst_int),
		.async_i (EXT_WAIT_PIN_I),
		.level_o (wait_sync)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st            = st_ff;
		nxt_st.rvalid     = 1'b0;
		nxt_st.init_start = 1'b0;
		nxt_st.hold_go    = 1'b0;
		evt               = '0;
		clr               = '0;
		reg_wr            = REG_REQ_I.we;
		wait_active       = st_ff.wpol ? wait_sync : ~wait_sync;
		drive             = 1'b0;
		if (rst_int) begin
			// Debugger reset ends on its own; watchdog waits like the pin
			nxt_st      = ST_RST;
			nxt_st.hold = WDOG_RST_I | (st_ff.hold & ~CLKCTL_RELEASE_I);
		end else begin
			// First cycle out of reset kicks off SDRAM initialization
			nxt_st.in_reset   = 1'b0;
			nxt_st.init_start = st_ff.in_reset;

			// Configuration writes
			if (reg_wr && REG_REQ_I.addr == OFS_WAIT_CFG) begin
				nxt_st.max_extend_wait_count = REG_REQ_I.wdata[MAX_EXTEND_WAIT_COUNT_LSB +: MAX_EXTEND_WAIT_COUNT_W];
				nxt_st.wpol = REG_REQ_I.wdata[WPOL_BIT];
			end
			if (reg_wr && REG_REQ_I.addr == OFS_ASYNC_CFG) begin
				nxt_st.async_bus_width = REG_REQ_I.wdata[ASYNC_BUS_WIDTH_LSB +: ASYNC_BUS_WIDTH_W];
			end
			if (reg_wr && REG_REQ_I.addr == OFS_EN_SET) begin
				nxt_st.en = st_ff.en | REG_REQ_I.wdata[EVT_W-1:0];
			end
			if (reg_wr && REG_REQ_I.addr == OFS_EN_CLR) begin
				nxt_st.en = st_ff.en & ~REG_REQ_I.wdata[EVT_W-1:0];
			end
			if (reg_wr && REG_REQ_I.addr == OFS_RAW) begin
				clr = REG_REQ_I.wdata[EVT_W-1:0];
			end

			// Rising edge of the filtered wait level, polarity not involved
			nxt_st.wait_q    = wait_sync;
			evt[BIT_WRISE]   = wait_sync & ~st_ff.wait_q;
			nxt_st.wait_act  = wait_active;

			// Extension counter: runs while wait holds the strobe open
			if (!STROBE_EXT_I) begin
				nxt_st.ext_cnt = '0;
				nxt_st.expired = 1'b0;
			end else if (wait_active && !st_ff.expired) begin
				if (st_ff.ext_cnt == st_ff.max_extend_wait_count) begin
					evt[BIT_TIMEOUT] = 1'b1;
					nxt_st.expired   = 1'b1;
					nxt_st.hold_go   = 1'b1;
				end else begin
					nxt_st.ext_cnt = st_ff.ext_cnt + 8'h01;
				end
			end

			// Status bits: a new event beats a clear in the same cycle
			nxt_st.raw    = (st_ff.raw & ~clr) | evt;
			nxt_st.masked = (st_ff.masked & ~clr) | (evt & st_ff.en);
			nxt_st.irq    = |nxt_st.masked;
			nxt_st.nmi    = (|nxt_st.masked) | DMA_NMI_I;

			// Width limited to 16 bits while the upper lines belong to the host
			if (HOST_NONMUX_SELECT_I && st_ff.async_bus_width != ASYNC_BUS_WIDTH_8) begin
				nxt_st.width = ASYNC_BUS_WIDTH_16;
			end else begin
				nxt_st.width = st_ff.async_bus_width;
			end

			// Register reads: answered one cycle later, unmapped reads zero
			if (REG_REQ_I.re) begin
				nxt_st.rvalid = 1'b1;
				nxt_st.rdata  = '0;
				case (REG_REQ_I.addr)
					OFS_WAIT_CFG: begin
						nxt_st.rdata[MAX_EXTEND_WAIT_COUNT_LSB +: MAX_EXTEND_WAIT_COUNT_W] = st_ff.max_extend_wait_count;
						nxt_st.rdata[WPOL_BIT]           = st_ff.wpol;
					end
					OFS_ASYNC_CFG: begin
						nxt_st.rdata[ASYNC_BUS_WIDTH_LSB +: ASYNC_BUS_WIDTH_W] = st_ff.async_bus_width;
					end
					OFS_RAW: begin
						nxt_st.rdata[EVT_W-1:0] = st_ff.raw;
					end
					OFS_MASKED: begin
						nxt_st.rdata[EVT_W-1:0] = st_ff.masked;
					end
					OFS_EN_SET, OFS_EN_CLR: begin
						nxt_st.rdata[EVT_W-1:0] = st_ff.en;
					end
					default: begin
						nxt_st.rdata = '0;
					end
				endcase
			end

			// Parking: the last write value is what the bus rests on
			if (WR_STROBE_I) begin
				nxt_st.park_data = WR_DATA_I;
			end
			case (st_ff.park)
				PARK_DRIVE, PARK_FLOAT: begin
					if (RD_CMD_I) begin
						nxt_st.park = PARK_READ;
					end else if (WR_STROBE_I) begin
						nxt_st.park = PARK_DRIVE;
					end
				end
				PARK_READ: begin
					if (RD_LAST_I) begin
						nxt_st.rd_data = MEMORY_DATA_BUS_I;
						// Floating inputs are the price of reading in self-refresh
						if (RD_ASYNC_I && SELF_REFRESH_I) begin
							nxt_st.park = PARK_FLOAT;
						end else begin
							nxt_st.park = PARK_DRIVE;
						end
					end
				end
				default: begin
					nxt_st.park = PARK_DRIVE;
				end
			endcase
			drive     = (nxt_st.park == PARK_DRIVE);
			// Upper half stays released in host mode so the host's address drive never fights us
			nxt_st.oe = {{HALF_W{drive & ~HOST_NONMUX_SELECT_I}}, {HALF_W{drive}}};
		end
	end

	// Registers
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign REG_RDATA_O             = st_ff.rdata;
	assign REG_RVALID_O            = st_ff.rvalid;
	assign MEMORY_DATA_BUS_O       = st_ff.park_data;
	assign MEMORY_DATA_BUS_OE_O    = st_ff.oe;
	assign ASYNC_BUS_WIDTH_O       = st_ff.width;
	assign RD_DATA_O               = st_ff.rd_data;
	assign WAIT_ACTIVE_O           = st_ff.wait_act;
	assign HOLD_GO_O               = st_ff.hold_go;
	assign SDRAM_INIT_START_O      = st_ff.init_start;
	assign IRQ_O                   = st_ff.irq;
	assign CPU_NONMASKABLE_INPUT_O = st_ff.nmi;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (rst_int);

	a_raw_wait_rise: assert property (
		(wait_sync && !st_ff.wait_q) |=> st_ff.raw[BIT_WRISE])
		else $error("wait rise did not set raw bit");
	a_masked_gate: assert property (
		((~st_ff.en & ~st_ff.masked) != '0)
		|=> ((~$past(st_ff.en) & ~$past(st_ff.masked) & st_ff.masked) == '0))
		else $error("masked bit set while disabled");
	a_raw_clear: assert property (
		(reg_wr && REG_REQ_I.addr == OFS_RAW && REG_REQ_I.wdata[BIT_TIMEOUT] && !evt[BIT_TIMEOUT])
		|=> (!st_ff.raw[BIT_TIMEOUT] && !st_ff.masked[BIT_TIMEOUT]))
		else $error("raw write did not clear both bits");
	a_enable_set: assert property (
		(reg_wr && REG_REQ_I.addr == OFS_EN_SET && REG_REQ_I.wdata[BIT_WRISE]) |=> st_ff.en[BIT_WRISE])
		else $error("enable set failed");
	a_enable_clear: assert property (
		(reg_wr && REG_REQ_I.addr == OFS_EN_CLR && REG_REQ_I.wdata[BIT_WRISE]) |=> !st_ff.en[BIT_WRISE])
		else $error("enable clear failed");
	a_enable_read: assert property (
		(REG_REQ_I.re && (REG_REQ_I.addr == OFS_EN_CLR || REG_REQ_I.addr == OFS_EN_SET))
		|=> (REG_RVALID_O && REG_RDATA_O[EVT_W-1:0] == $past(st_ff.en)))
		else $error("enable readback wrong");
	a_nmi_merge: assert property (
		(DMA_NMI_I || (|nxt_st.masked)) |=> CPU_NONMASKABLE_INPUT_O)
		else $error("nmi not merged");
	a_irq_follow: assert property (
		IRQ_O == (|st_ff.masked))
		else $error("irq not OR of masked bits");
	a_read_release: assert property (
		(st_ff.park == PARK_READ) |-> (MEMORY_DATA_BUS_OE_O == '0))
		else $error("bus driven during read");
	a_park_drive: assert property (
		(!st_ff.in_reset && st_ff.park == PARK_DRIVE && !$past(HOST_NONMUX_SELECT_I))
		|-> (MEMORY_DATA_BUS_OE_O == {DATA_W{1'b1}}))
		else $error("idle bus not parked");
	a_srf_float: assert property (
		(st_ff.park == PARK_READ && RD_LAST_I && RD_ASYNC_I && SELF_REFRESH_I)
		|=> (MEMORY_DATA_BUS_OE_O == '0) [*2])
		else $error("bus parked after self-refresh read");
	a_upper_free: assert property (
		$past(HOST_NONMUX_SELECT_I) |-> (MEMORY_DATA_BUS_OE_O[DATA_W-1:HALF_W] == '0))
		else $error("upper lines driven in host mode");
	a_init_start: assert property (
		$fell(rst_int) |=> SDRAM_INIT_START_O ##1 !SDRAM_INIT_START_O)
		else $error("init not started after reset");
	a_timeout_hold: assert property (
		evt[BIT_TIMEOUT] |=> (HOLD_GO_O && st_ff.raw[BIT_TIMEOUT]))
		else $error("timeout missed hold or raw bit");
	a_rise_once: assert property (
		evt[BIT_WRISE] |=> !evt[BIT_WRISE])
		else $error("one edge counted twice");
	a_hold_wait: assert property (@(posedge CLK_I) disable iff (RST_I)
		(st_ff.hold && !CLKCTL_RELEASE_I && !DBG_RST_I) |=> st_ff.hold)
		else $error("left reset before release");
	a_wdog_reset: assert property (@(posedge CLK_I) disable iff (RST_I)
		WDOG_RST_I |=> (st_ff.en == '0 && st_ff.raw == '0 && st_ff.hold))
		else $error("watchdog did not reset state");

	c_wrise_masked: cover property (evt[BIT_WRISE] && st_ff.en[BIT_WRISE] ##1 IRQ_O);
	c_timeout:      cover property (evt[BIT_TIMEOUT] ##1 HOLD_GO_O);
	c_srf_float:    cover property (st_ff.park == PARK_FLOAT);
	c_host_mode:    cover property (HOST_NONMUX_SELECT_I && st_ff.park == PARK_DRIVE);

endmodule // emipc_top

`default_nettype wire

// ===== design/emipc_pkg.sv
/*
 * Package of the external memory event, reset-entry and bus-parking block:
 * register offsets, field positions, reset values, park states and the
 * packed carriers shared by the top module and its testbench.
 * Assumes a single 50 MHz memory interface clock.
 */
package emipc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_WAIT_CFG  = 8'h04;
	localparam logic [7:0] OFS_ASYNC_CFG = 8'h10;
	localparam logic [7:0] OFS_RAW       = 8'h40;
	localparam logic [7:0] OFS_MASKED    = 8'h44;
	localparam logic [7:0] OFS_EN_SET    = 8'h48;
	localparam logic [7:0] OFS_EN_CLR    = 8'h4C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int EVT_W       = 2;
	localparam int BIT_WRISE   = 0;
	localparam int BIT_TIMEOUT = 1;
	localparam int MAX_EXTEND_WAIT_COUNT_LSB    = 0;
	localparam int MAX_EXTEND_WAIT_COUNT_W      = 8;
	localparam int WPOL_BIT    = 28;
	localparam int ASYNC_BUS_WIDTH_LSB   = 0;
	localparam int ASYNC_BUS_WIDTH_W     = 2;
	localparam int DATA_W      = 32;
	localparam int HALF_W      = 16;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [MAX_EXTEND_WAIT_COUNT_W-1:0]  RST_MAX_EXTEND_WAIT_COUNT  = 8'h80;
	localparam logic               RST_WPOL  = 1'b1;
	localparam logic [ASYNC_BUS_WIDTH_W-1:0] RST_ASYNC_BUS_WIDTH = 2'h0;
	localparam logic [ASYNC_BUS_WIDTH_W-1:0] ASYNC_BUS_WIDTH_8   = 2'h0;
	localparam logic [ASYNC_BUS_WIDTH_W-1:0] ASYNC_BUS_WIDTH_16  = 2'h1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PARK_DRIVE = 2'b00,
		PARK_READ  = 2'b01,
		PARK_FLOAT = 2'b10
	} emipc_park_type;

	// One register access request, sampled on a single clock edge
	typedef struct packed {
		logic [7:0]        addr;
		logic              we;
		logic              re;
		logic [DATA_W-1:0] wdata;
	} emipc_reg_req_type;

endpackage

// ===== design/emipc_sync3.sv
/*
 * Three-flop level synchroniser with agreement filter.
 * Assumes the input may change at any time relative to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module emipc_sync3 (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Level in and out
	input  wire logic async_i,
	output logic      level_o
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} emipc_sync_type;

	emipc_sync_type st_ff;
	emipc_sync_type nxt_st;

	// ----------------------------------------------------------------
	// Next state: s1 is read only by s2, output moves when s2 and s3 agree
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.s1    = async_i;
		nxt_st.s2    = st_ff.s1;
		nxt_st.s3    = st_ff.s2;
		if (st_ff.s2 == st_ff.s3) begin
			nxt_st.level = st_ff.s3;
		end
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level_o = st_ff.level;

endmodule // emipc_sync3

`default_nettype wire

// ===== test/emipc_mem_model.sv
/*
 * Far-side model: the external memory and its wait pin on the shared bus.
 * Assumes the bench sets the wait level and read word off the clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module emipc_mem_model (
	// Clock
	input  wire logic                         clk_i,
	// Bench controls
	input  wire logic                         wait_lvl_i,
	input  wire logic                         rd_en_i,
	input  wire logic [emipc_pkg::DATA_W-1:0] rd_word_i,
	// Bus side
	input  wire logic [emipc_pkg::DATA_W-1:0] bus_o_i,
	input  wire logic [emipc_pkg::DATA_W-1:0] oe_i,
	output logic      [emipc_pkg::DATA_W-1:0] bus_i_o,
	output logic                              wait_pin_o
);
	import emipc_pkg::*;

	logic [DATA_W-1:0] last_ff;

	// Wire level; upper lines have pull-ups, a lower bit left alone flips
	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			if (oe_i[i]) begin
				bus_i_o[i] = bus_o_i[i];
			end else if (rd_en_i) begin
				bus_i_o[i] = rd_word_i[i];
			end else if (i >= HALF_W) begin
				bus_i_o[i] = 1'b1;
			end else begin
				bus_i_o[i] = ~last_ff[i];
			end
		end
	end

	// Wait level registered so each level lasts whole clocks
	always_ff @(posedge clk_i) begin
		last_ff    <= bus_i_o;
		wait_pin_o <= wait_lvl_i;
	end
endmodule // emipc_mem_model

`default_nettype wire

// ===== test/test_emipc_top.sv
/*
 * Self-checking bench of the event, reset-entry and parking block.
 * Assumes the memory model beside it and a 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module test_emipc_top;
	import emipc_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic clk = 1'b0, rst = 1'b1, wdog = 1'b0, dbg = 1'b0, rel = 1'b1;
	logic wr_stb = 1'b0, rd_cmd = 1'b0, rd_last = 1'b0, rd_async = 1'b0;
	logic self_ref = 1'b0, strobe_ext = 1'b0, host_mux = 1'b0, dma_nmi = 1'b0;
	logic wait_lvl = 1'b0, rd_en = 1'b0;
	logic [DATA_W-1:0] wr_data = '0, rd_word = '0;
	emipc_reg_req_type req = '0;
	logic [DATA_W-1:0] rdata, bus_o, bus_in, oe, rd_data;
	logic              rvalid, wpin, wact, hold_go, init_go, irq, nmi;
	logic [ASYNC_BUS_WIDTH_W-1:0] width;
	int                bad_count = 0, num_checks = 0;

	always #10 clk = ~clk;

	emipc_top DUT (
		.CLK_I(clk), .RST_I(rst), .WDOG_RST_I(wdog), .DBG_RST_I(dbg),
		.CLKCTL_RELEASE_I(rel), .REG_REQ_I(req), .REG_RDATA_O(rdata),
		.REG_RVALID_O(rvalid), .WR_STROBE_I(wr_stb), .WR_DATA_I(wr_data),
		.RD_CMD_I(rd_cmd), .RD_LAST_I(rd_last), .RD_ASYNC_I(rd_async),
		.SELF_REFRESH_I(self_ref), .STROBE_EXT_I(strobe_ext), .EXT_WAIT_PIN_I(wpin),
		.MEMORY_DATA_BUS_I(bus_in), .MEMORY_DATA_BUS_O(bus_o),
		.MEMORY_DATA_BUS_OE_O(oe), .HOST_NONMUX_SELECT_I(host_mux),
		.ASYNC_BUS_WIDTH_O(width), .DMA_NMI_I(dma_nmi), .RD_DATA_O(rd_data),
		.WAIT_ACTIVE_O(wact), .HOLD_GO_O(hold_go), .SDRAM_INIT_START_O(init_go),
		.IRQ_O(irq), .CPU_NONMASKABLE_INPUT_O(nmi)
	);

	emipc_mem_model mem (
		.clk_i(clk), .wait_lvl_i(wait_lvl), .rd_en_i(rd_en), .rd_word_i(rd_word),
		.bus_o_i(bus_o), .oe_i(oe), .bus_i_o(bus_in), .wait_pin_o(wpin)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// Inputs always move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Strobes are lowered and an edge passes before the next access
	task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d);
		req = '{addr: a, we: 1'b1, re: 1'b0, wdata: d};
		tick(1);
		req.we = 1'b0;
		tick(1);
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [DATA_W-1:0] exp);
		req.addr = a;
		req.re = 1'b1;
		tick(1);
		req.re = 1'b0;
		chk(what, (rvalid === 1'b1) ? rdata : 32'hDEAD_0BAD, exp);
		tick(1);
	endtask

	task automatic wait_init(output int n);
		n = 0;
		while (init_go !== 1'b1 && n < 8) begin
			tick(1);
			n++;
		end
	endtask

	task automatic bus_read(input logic [DATA_W-1:0] w);
		rd_word = w;
		rd_en = 1'b1;
		rd_cmd = 1'b1;
		tick(1);
		rd_cmd = 1'b0;
		tick(1);
		chk("oe during read", oe, 32'h0);
		rd_last = 1'b1;
		tick(1);
		rd_last = 1'b0;
		rd_en = 1'b0;
	endtask

	task automatic park_write(input logic [DATA_W-1:0] w);
		wr_data = w;
		wr_stb = 1'b1;
		tick(1);
		wr_stb = 1'b0;
		tick(1);
		chk("parked data", bus_o, w);
		chk("parked oe", oe, '1);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [DATA_W-1:0] cfg;
		int n;
		chk("oe in reset", oe, 32'h0);
		rst = 1'b0;
		wait_init(n);
		chk("init delay", 32'(n <= 4), 32'h1);
		tick(1);
		chk("init pulse", {31'h0, init_go}, 32'h0);
		chk("idle oe", oe, '1);
		cfg = '0;
		cfg[WPOL_BIT] = RST_WPOL;
		cfg[MAX_EXTEND_WAIT_COUNT_W-1:0] = RST_MAX_EXTEND_WAIT_COUNT;
		rchk("wait cfg", OFS_WAIT_CFG, cfg);
		rchk("raw", OFS_RAW, 32'h0);
		rchk("unmapped", 8'h80, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_enable;
		wr(OFS_EN_SET, 32'h0);
		rchk("enable", OFS_EN_SET, 32'h0);
		wr(OFS_EN_SET, 32'h3);
		rchk("enable", OFS_EN_SET, 32'h3);
		rchk("enable clr", OFS_EN_CLR, 32'h3);
		wr(OFS_EN_CLR, 32'h0);
		rchk("enable", OFS_EN_SET, 32'h3);
		wr(OFS_EN_CLR, 32'h1);
		rchk("enable", OFS_EN_SET, 32'h2);
		rchk("enable clr", OFS_EN_CLR, 32'h2);
		wr(OFS_EN_CLR, 32'h2);
		$display("test enable done");
	endtask

	task automatic t_wrise;
		wait_lvl = 1'b1;
		tick(8);
		rchk("raw", OFS_RAW, 32'h1);
		rchk("masked", OFS_MASKED, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(OFS_EN_SET, 32'h1);
		rchk("masked", OFS_MASKED, 32'h0);
		wr(OFS_RAW, 32'h0);
		rchk("raw", OFS_RAW, 32'h1);
		wr(OFS_RAW, 32'h1);
		tick(4);
		rchk("raw", OFS_RAW, 32'h0);
		wait_lvl = 1'b0;
		tick(6);
		// Polarity flipped to low-active: rise must still count
		wr(OFS_WAIT_CFG, {24'h0, RST_MAX_EXTEND_WAIT_COUNT});
		wait_lvl = 1'b1;
		tick(8);
		rchk("raw", OFS_RAW, 32'h1);
		chk("wait active", {31'h0, wact}, 32'h0);
		rchk("masked", OFS_MASKED, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		chk("nmi", {31'h0, nmi}, 32'h1);
		wr(OFS_RAW, 32'h1);
		chk("irq", {31'h0, irq}, 32'h0);
		rchk("masked", OFS_MASKED, 32'h0);
		dma_nmi = 1'b1;
		tick(2);
		chk("nmi", {31'h0, nmi}, 32'h1);
		dma_nmi = 1'b0;
		wait_lvl = 1'b0;
		tick(6);
		wr(OFS_EN_CLR, 32'h1);
		$display("test wait rise done");
	endtask

	task automatic t_timeout;
		int n, m;
		wr(OFS_WAIT_CFG, 32'h1000_0003);
		wr(OFS_EN_SET, 32'h2);
		strobe_ext = 1'b1;
		wait_lvl = 1'b1;
		n = 0;
		while (wact !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		chk("wait active", {31'h0, wact}, 32'h1);
		m = 0;
		while (hold_go !== 1'b1 && m < 20) begin
			tick(1);
			m++;
		end
		chk("timeout delay", m, 32'h3);
		m = 0;
		repeat (10) begin
			tick(1);
			m += (hold_go === 1'b0) ? 0 : 1;
		end
		chk("one timeout", m, 32'h0);
		rchk("raw", OFS_RAW, 32'h3);
		rchk("masked", OFS_MASKED, 32'h2);
		strobe_ext = 1'b0;
		wait_lvl = 1'b0;
		tick(4);
		wr(OFS_RAW, 32'h3);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(OFS_EN_CLR, 32'h2);
		$display("test timeout done");
	endtask

	task automatic t_park;
		park_write(32'hA5C3_0F96);
		bus_read(32'h1E2D_3C4B);
		chk("oe after read", oe, '1);
		chk("read word", rd_data, 32'h1E2D_3C4B);
		chk("parked data", bus_o, 32'hA5C3_0F96);
		// Async read in self-refresh, against advice, to see the float
		self_ref = 1'b1;
		rd_async = 1'b1;
		bus_read(32'h5A69_7887);
		tick(3);
		chk("oe floated", oe, 32'h0);
		chk("read word", rd_data, 32'h5A69_7887);
		self_ref = 1'b0;
		rd_async = 1'b0;
		park_write(32'h0F1E_2D3C);
		$display("test parking done");
	endtask

	task automatic t_host;
		host_mux = 1'b1;
		wr(OFS_ASYNC_CFG, 32'h2);
		chk("width", {30'h0, width}, {30'h0, ASYNC_BUS_WIDTH_16});
		chk("oe shared", oe, 32'h0000_FFFF);
		wr(OFS_ASYNC_CFG, 32'h0);
		chk("width", {30'h0, width}, {30'h0, ASYNC_BUS_WIDTH_8});
		host_mux = 1'b0;
		wr(OFS_ASYNC_CFG, 32'h2);
		chk("width", {30'h0, width}, 32'h2);
		chk("oe", oe, '1);
		$display("test host done");
	endtask

	task automatic t_resets;
		int n;
		wr(OFS_EN_SET, 32'h3);
		rel = 1'b0;
		wdog = 1'b1;
		tick(3);
		wdog = 1'b0;
		tick(4);
		chk("oe held", oe, 32'h0);
		chk("init held", {31'h0, init_go}, 32'h0);
		rel = 1'b1;
		wait_init(n);
		chk("init delay", 32'(n <= 4), 32'h1);
		tick(1);
		rchk("enable", OFS_EN_SET, 32'h0);
		wr(OFS_EN_SET, 32'h3);
		rel = 1'b0;
		dbg = 1'b1;
		tick(3);
		dbg = 1'b0;
		wait_init(n);
		chk("init delay", 32'(n <= 4), 32'h1);
		rel = 1'b1;
		tick(1);
		rchk("enable", OFS_EN_SET, 32'h0);
		$display("test resets done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		tick(20);
		t_reset();
		t_enable();
		t_wrise();
		t_timeout();
		t_park();
		t_host();
		t_resets();
		print_verdict();
	end

	// Whole run is a few microseconds; far beyond that means a hang
	initial begin
		#100000;
		bad_count++;
		print_verdict();
	end
endmodule // test_emipc_top

`default_nettype wire
